/* verilog/wrx_pkg.sv */
// Constants and types for the wireless power receiver link
package wrx_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int ASK_BIT_HZ = 2000;
  localparam int ASK_HALF_CYC = CLK_HZ / (2 * ASK_BIT_HZ);
  localparam int ACK_WAIT_MS = 20;
  localparam int ACK_WAIT_CYC = (CLK_HZ / 1000) * ACK_WAIT_MS;
  localparam int OSC_KHZ = 60000;
  localparam logic [15:0] SHIFT_TICKS = 16'h0003;
  localparam logic [15:0] SHIFT_TOL = SHIFT_TICKS - 16'h0001;
  localparam logic [8:0] HALF_CYCLES = 9'h100;
  localparam logic [9:0] START_CYCLES = 10'h200;
  localparam logic [3:0] ASK_BYTE_BITS = 4'hB;
  localparam logic [3:0] FSK_BYTE_BITS = 4'hA;
  localparam logic [4:0] PREAMBLE_BITS = 5'h0B;
  localparam int WAIT_W = 24;
  localparam logic [7:0] HDR_STRENGTH = 8'h01;
  localparam logic [7:0] HDR_END = 8'h02;
  localparam logic [7:0] HDR_CTRL = 8'h03;
  localparam logic [7:0] HDR_POWER = 8'h04;
  localparam logic [7:0] HDR_NEGO = 8'h07;
  localparam logic [7:0] HDR_CONFIG = 8'h51;
  localparam int RSP_ACCEPT_BIT = 0;
  localparam int RSP_FOREIGN_BIT = 1;
  typedef enum logic [7:0] {
    PH_OFF = 8'h01, PH_PING = 8'h02, PH_IDCFG = 8'h04, PH_WAITACK = 8'h08,
    PH_NEGO = 8'h10, PH_CALIB = 8'h20, PH_XFER = 8'h40, PH_ENDING = 8'h80
  } wrx_phase_t;
  typedef enum logic [1:0] {FS_HUNT = 2'h1, FS_BITS = 2'h2} wrx_fsk_t;
  typedef enum logic [2:0] {AS_IDLE = 3'h1, AS_PRE = 3'h2, AS_BITS = 3'h4} wrx_ask_t;
endpackage : wrx_pkg

/* verilog/wrx_byte_if.sv */
// Byte stream carrier between the link's own modules
`timescale 1ns/1ps
interface wrx_byte_if;
  logic valid;
  logic ready;
  logic first;
  logic [7:0] data;
  modport src (output valid, output first, output data, input ready);
  modport snk (input valid, input first, input data, output ready);
endinterface : wrx_byte_if

/* verilog/wrx_buf2.sv */
// Two-entry byte buffer between packet builder and modulator
`timescale 1ns/1ps
module wrx_buf2 (
  input logic ref_clk,
  input logic rst,
  input logic ce,
  wrx_byte_if.snk in_if,
  wrx_byte_if.src out_if
);
  typedef struct packed {
    logic [1:0][8:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } wrx_buf_st_t;
  wrx_buf_st_t s;
  wrx_buf_st_t n;
  logic wr;
  logic rd;
  assign in_if.ready = ce && (s.cnt != 2'h2);
  assign out_if.valid = ce && (s.cnt != 2'h0);
  assign out_if.first = s.mem[s.rp][8];
  assign out_if.data = s.mem[s.rp][7:0];
  assign wr = in_if.valid && in_if.ready;
  assign rd = out_if.valid && out_if.ready;
  always_comb begin
    n = s;
    if (wr) begin
      n.mem[s.wp] = {in_if.first, in_if.data};
      n.wp = !s.wp;
    end
    if (rd) begin
      n.rp = !s.rp;
    end
    if (wr && !rd) begin
      n.cnt = s.cnt + 2'h1;
    end else if (rd && !wr) begin
      n.cnt = s.cnt - 2'h1;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : wrx_buf2

/* verilog/wrx_ask_enc.sv */
// Uplink bi-phase load modulator
`timescale 1ns/1ps
module wrx_ask_enc #(
  parameter int HALF_CYC = wrx_pkg::ASK_HALF_CYC
) (
  input logic ref_clk,
  input logic rst,
  input logic ce,
  wrx_byte_if.snk byte_if,
  output logic coil_node_a_switch,
  output logic coil_node_b_switch
);
  typedef struct packed {
    wrx_pkg::wrx_ask_t st;
    logic level;
    logic half;
    logic [15:0] hcnt;
    logic [10:0] sh;
    logic [3:0] nbit;
    logic [4:0] npre;
  } wrx_ask_st_t;
  wrx_ask_st_t s;
  wrx_ask_st_t n;
  logic tick;
  logic bitval;
  assign tick = s.hcnt == 16'(HALF_CYC - 1);
  assign bitval = (s.st == wrx_pkg::AS_PRE) || s.sh[0];
  assign byte_if.ready = ce && (s.st == wrx_pkg::AS_IDLE);
  assign coil_node_a_switch = s.level;
  assign coil_node_b_switch = s.level;
  always_comb begin
    n = s;
    if (ce) begin
      unique case (s.st)
        wrx_pkg::AS_IDLE: begin
          n.hcnt = 16'h0000;
          n.half = 1'b0;
          if (byte_if.valid) begin
            n.sh = {1'b1, ~^byte_if.data, byte_if.data, 1'b0};
            n.level = !s.level;
            n.nbit = 4'h0;
            n.npre = 5'h00;
            n.st = byte_if.first ? wrx_pkg::AS_PRE : wrx_pkg::AS_BITS;
          end else begin
            n.level = 1'b0;
          end
        end
        default: begin
          n.hcnt = tick ? 16'h0000 : s.hcnt + 16'h0001;
          if (tick && !s.half) begin
            n.half = 1'b1;
            if (bitval) begin
              n.level = !s.level;
            end
          end else if (tick) begin
            n.half = 1'b0;
            if (s.st == wrx_pkg::AS_PRE) begin
              n.level = !s.level;
              if (s.npre == wrx_pkg::PREAMBLE_BITS - 5'h01) begin
                n.st = wrx_pkg::AS_BITS;
              end else begin
                n.npre = s.npre + 5'h01;
              end
            end else if (s.nbit == wrx_pkg::ASK_BYTE_BITS - 4'h1) begin
              n.st = wrx_pkg::AS_IDLE;
            end else begin
              n.level = !s.level;
              n.nbit = s.nbit + 4'h1;
              n.sh = {1'b0, s.sh[10:1]};
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.st <= wrx_pkg::AS_IDLE;
    end else begin
      s <= n;
    end
  end
  AST_ASK_ZERO_MID: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && s.st == wrx_pkg::AS_BITS && tick && !s.half && !s.sh[0]) |=> s.level == $past(s.level))
    else $error("zero bit toggled mid-bit");
  AST_ASK_PARITY: assert property (@(posedge ref_clk) disable iff (rst)
    (s.st == wrx_pkg::AS_BITS && s.nbit == 4'h0) |-> (^s.sh[9:1] && s.sh[10] && !s.sh[0]))
    else $error("byte frame parity or stop wrong");
endmodule : wrx_ask_enc

/* verilog/wrx_link.sv */
// Top of the receiver communication link: phases, packets, downlink decode
`timescale 1ns/1ps
module wrx_link #(
  parameter int ASK_HALF_CYC = wrx_pkg::ASK_HALF_CYC,
  parameter int ACK_WAIT_CYC = wrx_pkg::ACK_WAIT_CYC
) (
  input logic ref_clk,
  input logic rst,
  input logic ce,
  input logic above_lockout,
  input logic power_sig,
  input logic osc_tick,
  input logic [7:0] signal_strength,
  input logic [7:0] config_msg,
  input logic nego_req,
  input logic [7:0] nego_msg,
  input logic [7:0] rectified_voltage,
  input logic [7:0] rectified_target,
  input logic [7:0] received_power,
  input logic ept_req,
  input logic [7:0] end_code,
  output logic rails_enable,
  output logic output_linear_regulator_en,
  output logic coil_node_a_switch,
  output logic coil_node_b_switch,
  output logic contract_5w,
  output logic foreign_object_detection_flag,
  output logic [7:0] phase_code,
  output logic [7:0] fsk_byte,
  output logic fsk_byte_valid,
  output logic fsk_parity_err
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    wrx_pkg::wrx_phase_t phase;
    logic sent;
    logic busy;
    logic [1:0] pos;
    logic [7:0] hdr;
    logic [7:0] msg;
    logic [wrx_pkg::WAIT_W-1:0] wcnt;
    logic rails_en;
    logic ldo_en;
    logic c5w;
    logic foreign;
    logic alt;
    logic prev_sig;
    logic [15:0] per;
    logic [15:0] ref_per;
    wrx_pkg::wrx_fsk_t fst;
    logic [9:0] run;
    logic [8:0] ccnt;
    logic half;
    logic h1;
    logic [3:0] nbit;
    logic [9:0] sh;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_perr;
  } wrx_link_st_t;

  wrx_link_st_t s;
  wrx_link_st_t n;
  logic cyc;
  logic is_short;
  logic [15:0] per_now;
  logic [9:0] new_sh;
  logic rx_ok;
  logic push;
  logic timeout;
  logic lw;
  logic [7:0] lh;
  logic [7:0] lm;

  wrx_byte_if pk_if ();
  wrx_byte_if tx_if ();

  // ----------------------------------------
  // Control error value
  // ----------------------------------------
  function automatic logic [7:0] ctrl_err(input logic [7:0] tgt, input logic [7:0] meas);
    logic signed [8:0] d;
    d = $signed({1'b0, tgt}) - $signed({1'b0, meas});
    if (d > 9'sh07F) begin
      ctrl_err = 8'h7F;
    end else if (d < -9'sh080) begin
      ctrl_err = 8'h80;
    end else begin
      ctrl_err = d[7:0];
    end
  endfunction : ctrl_err

  // ----------------------------------------
  // Downlink period measurement
  // ----------------------------------------
  assign cyc = power_sig && !s.prev_sig;
  assign per_now = s.per + {15'h0000, osc_tick};
  assign is_short = ({1'b0, per_now} + {1'b0, wrx_pkg::SHIFT_TOL}) <= {1'b0, s.ref_per};
  assign new_sh = {is_short != s.h1, s.sh[9:1]};
  assign rx_ok = (^new_sh[8:0]) && new_sh[9];

  // ----------------------------------------
  // Packet builder handshake
  // ----------------------------------------
  assign push = s.busy && pk_if.ready;
  assign pk_if.valid = s.busy;
  assign pk_if.first = s.pos == 2'h0;
  assign pk_if.data = (s.pos == 2'h0) ? s.hdr :
                      (s.pos == 2'h1) ? s.msg : (s.hdr ^ s.msg);
  assign timeout = s.wcnt == wrx_pkg::WAIT_W'(ACK_WAIT_CYC - 1);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    lw = 1'b0;
    lh = 8'h00;
    lm = 8'h00;
    if (ce) begin
      n.rx_valid = 1'b0;
      n.rx_perr = 1'b0;
      n.prev_sig = power_sig;
      if (cyc) begin
        n.per = 16'h0000;
        if (!is_short) begin
          n.ref_per = per_now;
        end
        unique case (s.fst)
          wrx_pkg::FS_HUNT: begin
            if (!is_short) begin
              n.run = 10'h000;
            end else if (s.run == wrx_pkg::START_CYCLES - 10'h001) begin
              n.fst = wrx_pkg::FS_BITS;
              n.ccnt = 9'h000;
              n.half = 1'b0;
              n.nbit = 4'h0;
            end else begin
              n.run = s.run + 10'h001;
            end
          end
          wrx_pkg::FS_BITS: begin
            n.ccnt = s.ccnt + 9'h001;
            if (s.ccnt == wrx_pkg::HALF_CYCLES - 9'h001) begin
              n.ccnt = 9'h000;
              n.half = !s.half;
              if (!s.half) begin
                n.h1 = is_short;
              end else begin
                n.sh = new_sh;
                n.nbit = s.nbit + 4'h1;
                if (s.nbit == wrx_pkg::FSK_BYTE_BITS - 4'h1) begin
                  n.fst = wrx_pkg::FS_HUNT;
                  n.run = 10'h000;
                  n.rx_byte = new_sh[7:0];
                  n.rx_valid = rx_ok;
                  n.rx_perr = !rx_ok;
                end
              end
            end
          end
          default: begin
            n.fst = wrx_pkg::FS_HUNT;
          end
        endcase
      end else begin
        n.per = per_now;
      end

      if (push) begin
        if (s.pos == 2'h2) begin
          n.busy = 1'b0;
        end else begin
          n.pos = s.pos + 2'h1;
        end
      end

      if (!above_lockout) begin
        n.phase = wrx_pkg::PH_OFF;
        n.rails_en = 1'b0;
        n.ldo_en = 1'b0;
        n.busy = 1'b0;
        n.sent = 1'b0;
        n.c5w = 1'b0;
        n.foreign = 1'b0;
      end else begin
        unique case (s.phase)
          wrx_pkg::PH_OFF: begin
            n.rails_en = 1'b1;
            n.phase = wrx_pkg::PH_PING;
            n.sent = 1'b0;
          end
          wrx_pkg::PH_PING: begin
            if (!s.sent) begin
              lw = 1'b1;
              lh = wrx_pkg::HDR_STRENGTH;
              lm = signal_strength;
              n.sent = !s.busy;
            end else if (!s.busy) begin
              n.phase = wrx_pkg::PH_IDCFG;
              n.sent = 1'b0;
            end
          end
          wrx_pkg::PH_IDCFG: begin
            if (!s.sent) begin
              lw = 1'b1;
              lh = wrx_pkg::HDR_CONFIG;
              lm = config_msg;
              n.sent = !s.busy;
            end else if (!s.busy) begin
              n.phase = wrx_pkg::PH_WAITACK;
              n.sent = 1'b0;
              n.wcnt = '0;
            end
          end
          wrx_pkg::PH_WAITACK: begin
            n.wcnt = s.wcnt + 1'b1;
            if (s.rx_valid && nego_req) begin
              n.phase = wrx_pkg::PH_NEGO;
            end else if (s.rx_valid || timeout) begin
              n.phase = wrx_pkg::PH_XFER;
              n.c5w = 1'b1;
              n.ldo_en = 1'b1;
            end
          end
          wrx_pkg::PH_NEGO: begin
            if (!s.sent) begin
              lw = 1'b1;
              lh = wrx_pkg::HDR_NEGO;
              lm = nego_msg;
              n.sent = !s.busy;
              n.wcnt = '0;
            end else if (!s.busy) begin
              n.wcnt = s.wcnt + 1'b1;
              if (s.rx_valid && s.rx_byte[wrx_pkg::RSP_FOREIGN_BIT]) begin
                n.foreign = 1'b1;
                n.phase = wrx_pkg::PH_ENDING;
                n.sent = 1'b0;
              end else if (s.rx_valid && s.rx_byte[wrx_pkg::RSP_ACCEPT_BIT]) begin
                n.phase = wrx_pkg::PH_CALIB;
                n.c5w = 1'b0;
                n.sent = 1'b0;
              end else if (s.rx_valid || timeout) begin
                n.phase = wrx_pkg::PH_XFER;
                n.c5w = 1'b1;
                n.ldo_en = 1'b1;
                n.sent = 1'b0;
              end
            end
          end
          wrx_pkg::PH_CALIB: begin
            if (!s.sent) begin
              lw = 1'b1;
              lh = wrx_pkg::HDR_POWER;
              lm = received_power;
              n.sent = !s.busy;
            end else if (!s.busy) begin
              n.phase = wrx_pkg::PH_XFER;
              n.ldo_en = 1'b1;
              n.sent = 1'b0;
            end
          end
          wrx_pkg::PH_XFER: begin
            if (ept_req) begin
              n.phase = wrx_pkg::PH_ENDING;
              n.ldo_en = 1'b0;
            end else begin
              lw = 1'b1;
              lh = s.alt ? wrx_pkg::HDR_POWER : wrx_pkg::HDR_CTRL;
              lm = s.alt ? received_power :
                   ctrl_err(rectified_target, rectified_voltage);
              if (!s.busy) begin
                n.alt = !s.alt;
              end
            end
          end
          wrx_pkg::PH_ENDING: begin
            n.ldo_en = 1'b0;
            lw = 1'b1;
            lh = wrx_pkg::HDR_END;
            lm = end_code;
          end
          default: begin
            n.phase = wrx_pkg::PH_OFF;
          end
        endcase
        if (lw && !s.busy) begin
          n.busy = 1'b1;
          n.pos = 2'h0;
          n.hdr = lh;
          n.msg = lm;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.phase <= wrx_pkg::PH_OFF;
      s.fst <= wrx_pkg::FS_HUNT;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Buffer and modulator
  // ----------------------------------------
  wrx_buf2 u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .in_if(pk_if),
    .out_if(tx_if)
  );

  wrx_ask_enc #(
    .HALF_CYC(ASK_HALF_CYC)
  ) u_enc (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .byte_if(tx_if),
    .coil_node_a_switch(coil_node_a_switch),
    .coil_node_b_switch(coil_node_b_switch)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rails_enable = s.rails_en;
  assign output_linear_regulator_en = s.ldo_en;
  assign contract_5w = s.c5w;
  assign foreign_object_detection_flag = s.foreign;
  assign phase_code = s.phase;
  assign fsk_byte = s.rx_byte;
  assign fsk_byte_valid = s.rx_valid;
  assign fsk_parity_err = s.rx_perr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence seq_end_requested;
    ce && above_lockout && s.phase == wrx_pkg::PH_XFER && ept_req;
  endsequence

  sequence seq_ending_held;
    s.phase == wrx_pkg::PH_ENDING && !output_linear_regulator_en;
  endsequence

  AST_LOCKOUT_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && !above_lockout) |=> (s.phase == wrx_pkg::PH_OFF && !rails_enable && !s.busy))
    else $error("lockout did not stop the link");

  AST_RAILS_START: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && above_lockout && s.phase == wrx_pkg::PH_OFF)
      |=> (rails_enable && s.phase == wrx_pkg::PH_PING))
    else $error("supplies not released before ping");

  AST_END_REPEAT: assert property (@(posedge ref_clk) disable iff (rst)
    seq_end_requested ##1 (ce && above_lockout)[*2] |-> seq_ending_held)
    else $error("end request not held with regulator off");

  AST_CHECKSUM: assert property (@(posedge ref_clk) disable iff (rst)
    (push && s.pos == 2'h2) |-> (pk_if.data == (s.hdr ^ s.msg) && !pk_if.first))
    else $error("checksum byte wrong");

  AST_HEADER_FIRST: assert property (@(posedge ref_clk) disable iff (rst)
    (push && s.pos == 2'h0) |-> (pk_if.first && pk_if.data == s.hdr) ##1 (s.pos == 2'h1))
    else $error("header not first in packet");

  AST_ACK_TIMEOUT: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && above_lockout && s.phase == wrx_pkg::PH_WAITACK && timeout && !s.rx_valid)
      |=> (s.phase == wrx_pkg::PH_XFER && contract_5w && output_linear_regulator_en))
    else $error("no 5 W fallback after silent acknowledge window");

  AST_SHIFT_DETECT: assert property (@(posedge ref_clk) disable iff (rst)
    (per_now + wrx_pkg::SHIFT_TICKS == s.ref_per) |-> is_short)
    else $error("3 tick shorter period not seen as shifted");

  AST_START_BIT: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && cyc && is_short && s.fst == wrx_pkg::FS_HUNT
      && s.run == wrx_pkg::START_CYCLES - 10'h001)
      |=> (s.fst == wrx_pkg::FS_BITS && s.nbit == 4'h0 && s.ccnt == 9'h000))
    else $error("start bit of 512 shifted cycles missed");

endmodule : wrx_link

/* tb/wrx_tx_model.sv */
// Transmitter model: power signal, downlink shifting, uplink decode
`timescale 1ns/1ps
module wrx_tx_model (
  input logic ref_clk,
  input logic coil,
  output logic power_sig,
  output logic osc_tick
);
  logic [7:0] q[$];
  logic [7:0] rxq[$];
  logic pl = 1'b0;
  logic half = 1'b0;
  int gap = 100;
  int nb = 0;
  logic [9:0] sr = 10'h000;
  // ----------------------------------------
  // Downlink power cycles
  // ----------------------------------------
  assign osc_tick = 1'b1;
  task automatic cyc(input int n, input logic s);
    repeat (n) begin
      power_sig <= 1'b1;
      @(posedge ref_clk);
      power_sig <= 1'b0;
      repeat (s ? 1 : 4) @(posedge ref_clk);
    end
  endtask : cyc
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    logic l;
    f = {1'b1, ~^b, b};
    l = 1'b1;
    cyc(512, 1'b1);
    for (int i = 0; i < 10; i++) begin
      l = ~l;
      cyc(256, l);
      if (f[i]) l = ~l;
      cyc(256, l);
    end
  endtask : send
  initial begin
    power_sig = 1'b0;
    @(posedge ref_clk);
    forever begin
      if (q.size() > 0) send(q.pop_front());
      else cyc(1, 1'b0);
    end
  end
  // ----------------------------------------
  // Uplink bi-phase decode
  // ----------------------------------------
  task automatic put(input logic b);
    logic [9:0] v;
    v = {b, sr[9:1]};
    sr <= v;
    nb <= (nb == 0 && b) ? 0 : (nb == 10 ? 0 : nb + 1);
    if (nb == 10) rxq.push_back((v[9] && ^v[8:0]) ? v[7:0] : 8'hEE);
  endtask : put
  always @(posedge ref_clk) begin
    pl <= coil;
    gap <= gap + 1;
    if (coil != pl) begin
      gap <= 0;
      if (gap > 20) begin
        half <= 1'b0;
        nb <= 0;
      end else if (gap > 11) put(1'b0);
      else if (half) begin
        half <= 1'b0;
        put(1'b1);
      end else half <= 1'b1;
    end else if (gap == 20 && half) begin
      half <= 1'b0;
      put(1'b1);
    end
  end
endmodule : wrx_tx_model

/* tb/wrx_link_tb_top.sv */
// Self-checking bench for the receiver communication link
`timescale 1ns/1ps
module wrx_link_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic above_lockout = 1'b0;
  logic nego_req = 1'b0;
  logic ept_req = 1'b0;
  logic [7:0] sstr, cfg, nmsg, vr, rp, ecode, b;
  logic rails, reg_en, sw_a, sw_b, c5w, foreign_object_detection, fv, ferr, psig, tick;
  logic [7:0] phase, fb;
  logic [7:0] up_q[$];
  logic [7:0] dn_q[$];
  logic [31:0] seed = 32'h00000030;
  int miscompares = 0;
  int n_checks = 0;
  int k;
  initial forever #5 ref_clk = ~ref_clk;
  wrx_link #(.ASK_HALF_CYC(8), .ACK_WAIT_CYC(25000)) wrx_link_i (
    .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .above_lockout(above_lockout),
    .power_sig(psig), .osc_tick(tick), .signal_strength(sstr), .config_msg(cfg),
    .nego_req(nego_req), .nego_msg(nmsg), .rectified_voltage(vr),
    .rectified_target(vr + 8'h05), .received_power(rp), .ept_req(ept_req),
    .end_code(ecode), .rails_enable(rails), .output_linear_regulator_en(reg_en),
    .coil_node_a_switch(sw_a), .coil_node_b_switch(sw_b), .contract_5w(c5w),
    .foreign_object_detection_flag(foreign_object_detection), .phase_code(phase), .fsk_byte(fb),
    .fsk_byte_valid(fv), .fsk_parity_err(ferr));
  wrx_tx_model tx_i (.ref_clk(ref_clk), .coil(sw_a), .power_sig(psig), .osc_tick(tick));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic pk(input logic [7:0] h, input logic [7:0] m);
    up_q.push_back(h);
    up_q.push_back(m);
    up_q.push_back(h ^ m);
  endtask : pk
  task automatic dl(input logic [7:0] v);
    tx_i.q.push_back(v);
    dn_q.push_back(v);
  endtask : dl
  task automatic wph(input logic [7:0] p);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (phase !== p && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("phase", phase, p);
  endtask : wph
  task automatic drain();
    int n;
    n = 0;
    while (up_q.size() > 0 && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("pending", 8'(up_q.size()), 8'h00);
  endtask : drain
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(negedge ref_clk) begin
    if (!rst) chk("coil_pair", {7'h00, sw_a}, {7'h00, sw_b});
    if (tx_i.rxq.size() > 0 && up_q.size() > 0) begin
      chk("uplink", tx_i.rxq.pop_front(), up_q.pop_front());
    end
    if (fv) chk("downlink", fb, dn_q.pop_front());
    if (ferr) chk("frame_err", 8'h01, 8'h00);
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    sstr = rnd();
    cfg = rnd();
    nmsg = rnd();
    vr = rnd() & 8'h7F;
    rp = 8'h3C;
    ecode = rnd() | 8'h80;
    pk(wrx_pkg::HDR_STRENGTH, sstr);
    pk(wrx_pkg::HDR_CONFIG, cfg);
    repeat (16) @(posedge ref_clk);
    chk("phase_rst", phase, 8'h01);
    rst <= 1'b0;
    above_lockout <= 1'b1;
    wph(8'h02);
    chk("rails", {7'h00, rails}, 8'h01);
    wph(8'h40);
    chk("c5w", {7'h00, c5w}, 8'h01);
    chk("reg_on", {7'h00, reg_en}, 8'h01);
    pk(wrx_pkg::HDR_CTRL, 8'h05);
    pk(wrx_pkg::HDR_POWER, rp);
    drain();
    @(posedge ref_clk);
    ept_req <= 1'b1;
    wph(8'h80);
    chk("reg_off", {7'h00, reg_en}, 8'h00);
    k = 0;
    while (k < 3000) begin
      @(negedge ref_clk);
      k++;
      if (tx_i.rxq.size() > 0 && tx_i.rxq.pop_front() === wrx_pkg::HDR_END) k = 9999;
    end
    chk("end_seen", {7'h00, k == 9999}, 8'h01);
    up_q = '{ecode, wrx_pkg::HDR_END ^ ecode};
    pk(wrx_pkg::HDR_END, ecode);
    drain();
    @(posedge ref_clk);
    above_lockout <= 1'b0;
    ept_req <= 1'b0;
    nego_req <= 1'b1;
    wph(8'h01);
    chk("rails_off", {7'h00, rails}, 8'h00);
    repeat (1200) @(posedge ref_clk);
    tx_i.rxq.delete();
    pk(wrx_pkg::HDR_STRENGTH, sstr);
    pk(wrx_pkg::HDR_CONFIG, cfg);
    above_lockout <= 1'b1;
    wph(8'h08);
    dl(rnd());
    wph(8'h10);
    pk(wrx_pkg::HDR_NEGO, nmsg);
    pk(wrx_pkg::HDR_POWER, rp);
    b = (rnd() | 8'h01) & 8'hFD;
    dl(b);
    wph(8'h20);
    wph(8'h40);
    chk("c5w_nego", {7'h00, c5w}, 8'h00);
    chk("fod", {7'h00, foreign_object_detection}, 8'h00);
    drain();
    wrap_up();
  end
endmodule : wrx_link_tb_top
